// file: asld_pkg.sv
package asld_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] ASLD_IDX_START_DELAY = 10'h007;
  localparam logic [9:0] ASLD_IDX_EVENT_LOCK  = 10'h008;
  localparam logic [9:0] ASLD_IDX_WAVE_LOCK   = 10'h009;
  localparam logic [9:0] ASLD_IDX_STAGE_STAT  = 10'h00a;

  localparam int ASLD_ADDR_W = 12;
  localparam int ASLD_DATA_W = 32;

  // Field positions
  localparam int ASLD_PORT_A_LSB     = 0;
  localparam int ASLD_PORT_B_LSB     = 2;
  localparam int ASLD_EVT_LOW_BIT    = 0;
  localparam int ASLD_EVT_HIGH_BIT   = 4;
  localparam int ASLD_WAVE_C_BIT     = 0;
  localparam int ASLD_WAVE_E_BIT     = 2;
  localparam int ASLD_STAT_A_BIT     = 0;
  localparam int ASLD_STAT_B_BIT     = 1;

  localparam logic [7:0] ASLD_RESET_VALUE = 8'h00;

  // Stagger delay codes
  typedef enum logic [1:0] {
    ASLD_DIRECT_START          = 2'h0,
    ASLD_TWO_CYCLE_STEP        = 2'h1,
    ASLD_EIGHT_CYCLE_STEP      = 2'h2,
    ASLD_THIRTY_TWO_CYCLE_STEP = 2'h3
  } asld_delay_t;

  localparam int ASLD_CNT_W = 6;
  localparam logic [ASLD_CNT_W-1:0] ASLD_STEP_TWO        = 6'h02;
  localparam logic [ASLD_CNT_W-1:0] ASLD_STEP_EIGHT      = 6'h08;
  localparam logic [ASLD_CNT_W-1:0] ASLD_STEP_THIRTY_TWO = 6'h20;
  localparam logic [ASLD_CNT_W-1:0] ASLD_CNT_ONE         = 6'h01;
endpackage

// file: asld_stagger.sv
`timescale 1ns/1ns
module asld_stagger
  import asld_pkg::*;
#(
  parameter int STAGES = 3
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Control
  input  wire logic              enable,
  input  wire logic [1:0]        delay_code,
  // Stage outputs
  output logic [STAGES-1:0]      stage_en,
  output logic                   busy
);

  typedef enum logic [1:0] {ST_OFF, ST_RAMP, ST_ON} asld_stg_t;

  generate
    if (STAGES < 2) begin : g_chk
      $error("asld_stagger needs at least two stages");
    end
  endgenerate

  function automatic logic [ASLD_CNT_W-1:0] step_len(input logic [1:0] code);
    unique case (asld_delay_t'(code))
      ASLD_TWO_CYCLE_STEP:   step_len = ASLD_STEP_TWO;
      ASLD_EIGHT_CYCLE_STEP: step_len = ASLD_STEP_EIGHT;
      default:               step_len = ASLD_STEP_THIRTY_TWO;
    endcase
  endfunction

  asld_stg_t               state;
  asld_stg_t               next_state;
  logic [ASLD_CNT_W-1:0]   cnt;
  logic [ASLD_CNT_W-1:0]   next_cnt;
  logic [1:0]              code;
  logic [1:0]              next_code;
  logic [STAGES-1:0]       next_stage_en;
  logic                    next_busy;

  // Code is latched at enable so a mid-ramp rewrite cannot stretch a step
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_code     = code;
    next_stage_en = stage_en;
    unique case (state)
      ST_OFF: begin
        if (enable) begin
          next_code = delay_code;
          if (delay_code == ASLD_DIRECT_START) begin
            next_stage_en = '1;
            next_state    = ST_ON;
          end else begin
            next_stage_en = {{(STAGES-1){1'b0}}, 1'b1};
            next_cnt      = step_len(delay_code) - ASLD_CNT_ONE;
            next_state    = ST_RAMP;
          end
        end
      end
      ST_RAMP: begin
        if (!enable) begin
          next_stage_en = '0;
          next_state    = ST_OFF;
        end else if (cnt == '0) begin
          next_stage_en = {stage_en[STAGES-2:0], 1'b1};
          next_cnt      = step_len(code) - ASLD_CNT_ONE;
          if (stage_en[STAGES-2]) begin
            next_state = ST_ON;
          end
        end else begin
          next_cnt = cnt - ASLD_CNT_ONE;
        end
      end
      ST_ON: begin
        if (!enable) begin
          next_stage_en = '0;
          next_state    = ST_OFF;
        end
      end
    endcase
    next_busy = (next_state == ST_RAMP);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= ST_OFF;
      cnt      <= '0;
      code     <= '0;
      stage_en <= '0;
      busy     <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      code     <= next_code;
      stage_en <= next_stage_en;
      busy     <= next_busy;
    end
  end

  a_direct_start: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OFF && enable && delay_code == ASLD_DIRECT_START) |=> (stage_en == '1))
    else $error("direct start did not raise all stages");
  a_two_step: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OFF && enable && delay_code == ASLD_TWO_CYCLE_STEP) ##1 enable[*2]
    |=> (stage_en[1:0] == 2'h3) || !enable)
    else $error("two cycle step spacing wrong");
  a_eight_hold: assert property (@(posedge clk) disable iff (rst)
    (state == ST_OFF && enable && delay_code == ASLD_EIGHT_CYCLE_STEP) ##1 enable[*7]
    |-> (stage_en[1] == 1'b0))
    else $error("eight cycle step came early");
  a_disable_clears: assert property (@(posedge clk) disable iff (rst)
    (state != ST_OFF && !enable) |=> (stage_en == '0))
    else $error("stages not dropped on disable");
  a_one_at_a_time: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RAMP) |=> ($countones(stage_en) <= $countones($past(stage_en)) + 1))
    else $error("more than one stage started at once");

  c_ramp_done: cover property (@(posedge clk) disable iff (rst)
    (state == ST_RAMP) ##1 (state == ST_ON));
  c_abort: cover property (@(posedge clk) disable iff (rst)
    (state == ST_RAMP && !enable));

endmodule

// file: asld_ctrl.sv
// Register access over APB was decided locally.
`timescale 1ns/1ns
module asld_ctrl
  import asld_pkg::*;
#(
  parameter int STAGES = 3
) (
  // Clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST,
  // APB slave
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [ASLD_ADDR_W-1:0] PADDR,
  input  wire logic [ASLD_DATA_W-1:0] PWDATA,
  input  wire logic [3:0]             PSTRB,
  output logic [ASLD_DATA_W-1:0]      PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  // Protection and analog enables
  input  wire logic                   CCP_OPEN,
  input  wire logic                   PORT_A_ANALOG_EN,
  input  wire logic                   PORT_B_ANALOG_EN,
  // Stage enables
  output logic [STAGES-1:0]           PORT_A_STAGE_EN,
  output logic [STAGES-1:0]           PORT_B_STAGE_EN,
  // Lock outputs
  output logic                        LOW_EVENT_GROUP_LOCK,
  output logic                        HIGH_EVENT_GROUP_LOCK,
  output logic                        PORT_E_WAVEFORM_LOCK,
  output logic                        PORT_C_WAVEFORM_LOCK
);

  function automatic logic known_index(input logic [9:0] idx);
    known_index = (idx == ASLD_IDX_START_DELAY) || (idx == ASLD_IDX_EVENT_LOCK) ||
                  (idx == ASLD_IDX_WAVE_LOCK) || (idx == ASLD_IDX_STAGE_STAT);
  endfunction

  // Bits each register really holds; every other bit must read as zero
  function automatic logic [7:0] live_bits(input logic [9:0] idx_in);
    live_bits = ASLD_RESET_VALUE;
    unique case (idx_in)
      ASLD_IDX_START_DELAY: begin
        live_bits[ASLD_PORT_A_LSB +: 2] = 2'h3;
        live_bits[ASLD_PORT_B_LSB +: 2] = 2'h3;
      end
      ASLD_IDX_EVENT_LOCK: begin
        live_bits[ASLD_EVT_LOW_BIT]  = 1'b1;
        live_bits[ASLD_EVT_HIGH_BIT] = 1'b1;
      end
      ASLD_IDX_WAVE_LOCK: begin
        live_bits[ASLD_WAVE_C_BIT] = 1'b1;
        live_bits[ASLD_WAVE_E_BIT] = 1'b1;
      end
      ASLD_IDX_STAGE_STAT: begin
        live_bits[ASLD_STAT_A_BIT] = 1'b1;
        live_bits[ASLD_STAT_B_BIT] = 1'b1;
      end
      default: live_bits = ASLD_RESET_VALUE;
    endcase
  endfunction

  logic [1:0]              port_a_stagger_delay;
  logic [1:0]              port_b_stagger_delay;
  logic [1:0]              next_port_a_stagger_delay;
  logic [1:0]              next_port_b_stagger_delay;
  logic                    next_low_lock;
  logic                    next_high_lock;
  logic                    next_wave_e_lock;
  logic                    next_wave_c_lock;
  logic [ASLD_DATA_W-1:0]  next_prdata;
  logic                    next_pready;
  logic                    next_pslverr;
  logic                    busy_a;
  logic                    busy_b;
  logic [9:0]              idx;
  logic                    setup;
  logic                    wr_take;
  logic [7:0]              wbyte;
  logic [7:0]              rbyte;

  assign idx     = PADDR[ASLD_ADDR_W-1:2];
  assign setup   = PSEL && !PENABLE;
  assign wr_take = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && known_index(idx);
  assign wbyte   = PWDATA[7:0];

  // No wait state: read data is registered in setup and shown in access
  always_comb begin
    rbyte = ASLD_RESET_VALUE;
    unique case (idx)
      ASLD_IDX_START_DELAY: begin
        rbyte[ASLD_PORT_A_LSB +: 2] = port_a_stagger_delay;
        rbyte[ASLD_PORT_B_LSB +: 2] = port_b_stagger_delay;
      end
      ASLD_IDX_EVENT_LOCK: begin
        rbyte[ASLD_EVT_LOW_BIT]  = LOW_EVENT_GROUP_LOCK;
        rbyte[ASLD_EVT_HIGH_BIT] = HIGH_EVENT_GROUP_LOCK;
      end
      ASLD_IDX_WAVE_LOCK: begin
        rbyte[ASLD_WAVE_C_BIT] = PORT_C_WAVEFORM_LOCK;
        rbyte[ASLD_WAVE_E_BIT] = PORT_E_WAVEFORM_LOCK;
      end
      ASLD_IDX_STAGE_STAT: begin
        rbyte[ASLD_STAT_A_BIT] = busy_a;
        rbyte[ASLD_STAT_B_BIT] = busy_b;
      end
      default: rbyte = ASLD_RESET_VALUE;
    endcase
    next_pready  = setup;
    next_pslverr = setup && !known_index(idx);
    next_prdata  = PRDATA;
    if (setup) begin
      next_prdata = (!PWRITE) ? {{(ASLD_DATA_W-8){1'b0}}, rbyte} : '0;
    end
  end

  always_comb begin
    next_port_a_stagger_delay = port_a_stagger_delay;
    next_port_b_stagger_delay = port_b_stagger_delay;
    next_low_lock             = LOW_EVENT_GROUP_LOCK;
    next_high_lock            = HIGH_EVENT_GROUP_LOCK;
    next_wave_e_lock          = PORT_E_WAVEFORM_LOCK;
    next_wave_c_lock          = PORT_C_WAVEFORM_LOCK;
    if (wr_take && idx == ASLD_IDX_START_DELAY) begin
      next_port_a_stagger_delay = wbyte[ASLD_PORT_A_LSB +: 2];
      next_port_b_stagger_delay = wbyte[ASLD_PORT_B_LSB +: 2];
    end
    // Locks only ever set; a clear would reopen a frozen peripheral
    if (wr_take && CCP_OPEN && idx == ASLD_IDX_EVENT_LOCK) begin
      next_low_lock  = LOW_EVENT_GROUP_LOCK || wbyte[ASLD_EVT_LOW_BIT];
      next_high_lock = HIGH_EVENT_GROUP_LOCK || wbyte[ASLD_EVT_HIGH_BIT];
    end
    if (wr_take && CCP_OPEN && idx == ASLD_IDX_WAVE_LOCK) begin
      next_wave_e_lock = PORT_E_WAVEFORM_LOCK || wbyte[ASLD_WAVE_E_BIT];
      next_wave_c_lock = PORT_C_WAVEFORM_LOCK || wbyte[ASLD_WAVE_C_BIT];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      port_a_stagger_delay  <= '0;
      port_b_stagger_delay  <= '0;
      LOW_EVENT_GROUP_LOCK  <= 1'b0;
      HIGH_EVENT_GROUP_LOCK <= 1'b0;
      PORT_E_WAVEFORM_LOCK  <= 1'b0;
      PORT_C_WAVEFORM_LOCK  <= 1'b0;
      PRDATA                <= '0;
      PREADY                <= 1'b0;
      PSLVERR               <= 1'b0;
    end else begin
      port_a_stagger_delay  <= next_port_a_stagger_delay;
      port_b_stagger_delay  <= next_port_b_stagger_delay;
      LOW_EVENT_GROUP_LOCK  <= next_low_lock;
      HIGH_EVENT_GROUP_LOCK <= next_high_lock;
      PORT_E_WAVEFORM_LOCK  <= next_wave_e_lock;
      PORT_C_WAVEFORM_LOCK  <= next_wave_c_lock;
      PRDATA                <= next_prdata;
      PREADY                <= next_pready;
      PSLVERR               <= next_pslverr;
    end
  end

  // Enables come from logic on this clock, so no synchroniser
  asld_stagger #(.STAGES(STAGES)) u_port_a (
    .clk        (CLK),
    .rst        (RST),
    .enable     (PORT_A_ANALOG_EN),
    .delay_code (port_a_stagger_delay),
    .stage_en   (PORT_A_STAGE_EN),
    .busy       (busy_a)
  );

  asld_stagger #(.STAGES(STAGES)) u_port_b (
    .clk        (CLK),
    .rst        (RST),
    .enable     (PORT_B_ANALOG_EN),
    .delay_code (port_b_stagger_delay),
    .stage_en   (PORT_B_STAGE_EN),
    .busy       (busy_b)
  );

  a_lock_sticky: assert property (@(posedge CLK) disable iff (RST)
    $rose(LOW_EVENT_GROUP_LOCK) |=> LOW_EVENT_GROUP_LOCK [*8])
    else $error("event lock cleared without reset");
  a_lock_needs_ccp: assert property (@(posedge CLK) disable iff (RST)
    (!CCP_OPEN && PSEL && PENABLE && PREADY) |=>
      $stable({LOW_EVENT_GROUP_LOCK, HIGH_EVENT_GROUP_LOCK,
               PORT_E_WAVEFORM_LOCK, PORT_C_WAVEFORM_LOCK}))
    else $error("lock changed while protection closed");
  a_high_lock_set: assert property (@(posedge CLK) disable iff (RST)
    (wr_take && CCP_OPEN && idx == ASLD_IDX_EVENT_LOCK && PWDATA[ASLD_EVT_HIGH_BIT])
    |=> HIGH_EVENT_GROUP_LOCK)
    else $error("high event lock not set");
  a_wave_e_set: assert property (@(posedge CLK) disable iff (RST)
    (wr_take && CCP_OPEN && idx == ASLD_IDX_WAVE_LOCK && PWDATA[ASLD_WAVE_E_BIT])
    |=> PORT_E_WAVEFORM_LOCK)
    else $error("port e waveform lock not set");
  a_wave_c_set: assert property (@(posedge CLK) disable iff (RST)
    (wr_take && CCP_OPEN && idx == ASLD_IDX_WAVE_LOCK && PWDATA[ASLD_WAVE_C_BIT])
    |=> PORT_C_WAVEFORM_LOCK)
    else $error("port c waveform lock not set");
  a_low_lock_set: assert property (@(posedge CLK) disable iff (RST)
    (wr_take && CCP_OPEN && idx == ASLD_IDX_EVENT_LOCK && PWDATA[ASLD_EVT_LOW_BIT])
    |=> LOW_EVENT_GROUP_LOCK)
    else $error("low event lock not set");
  // Lock register keeps bit 4 live, so the check follows each register's own map
  a_upper_zero: assert property (@(posedge CLK) disable iff (RST)
    (PREADY && PSEL && !PWRITE) |->
      (((PRDATA[7:0] & ~live_bits(idx)) == '0) && (PRDATA[ASLD_DATA_W-1:8] == '0)))
    else $error("unused bits read nonzero");
  a_locks_stay_set: assert property (@(posedge CLK) disable iff (RST)
    !$fell(LOW_EVENT_GROUP_LOCK) && !$fell(HIGH_EVENT_GROUP_LOCK) &&
    !$fell(PORT_E_WAVEFORM_LOCK) && !$fell(PORT_C_WAVEFORM_LOCK))
    else $error("lock cleared without reset");
  a_delay_write: assert property (@(posedge CLK) disable iff (RST)
    (wr_take && idx == ASLD_IDX_START_DELAY) |=>
      ({port_b_stagger_delay, port_a_stagger_delay} ==
       {$past(PWDATA[ASLD_PORT_B_LSB +: 2]), $past(PWDATA[ASLD_PORT_A_LSB +: 2])}))
    else $error("stagger fields not written");
  a_error_quiet: assert property (@(posedge CLK) disable iff (RST)
    PSLVERR |-> (PREADY && (PRDATA == '0)))
    else $error("slave error without ready or with data");
  a_ready_timing: assert property (@(posedge CLK) disable iff (RST)
    (PSEL && !PENABLE) |=> (PREADY && (PSLVERR == !known_index($past(idx)))))
    else $error("ready or error not one cycle after setup");

  c_lock_write: cover property (@(posedge CLK) disable iff (RST)
    $rose(PORT_E_WAVEFORM_LOCK));
  c_refused_lock: cover property (@(posedge CLK) disable iff (RST)
    (wr_take && !CCP_OPEN && idx == ASLD_IDX_EVENT_LOCK));
  c_unmapped: cover property (@(posedge CLK) disable iff (RST) PSLVERR);

endmodule

// file: test_analog_start_and_lock_control.sv
`timescale 1ns/1ns
module test_analog_start_and_lock_control;
  import asld_pkg::*;
  logic                   clk_i;
  logic                   rst_i;
  logic                   psel, penable, pwrite;
  logic [ASLD_ADDR_W-1:0] paddr;
  logic [ASLD_DATA_W-1:0] pwdata, prdata;
  logic                   pready, pslverr, ccp_open, en_a, en_b;
  logic [2:0]             stage_a, stage_b;
  logic                   lk_low, lk_high, lk_e, lk_c;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  int                     cycles = 0;

  asld_ctrl #(.STAGES(3)) DUT (
    .CLK(clk_i), .RST(rst_i), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CCP_OPEN(ccp_open), .PORT_A_ANALOG_EN(en_a),
    .PORT_B_ANALOG_EN(en_b), .PORT_A_STAGE_EN(stage_a), .PORT_B_STAGE_EN(stage_b),
    .LOW_EVENT_GROUP_LOCK(lk_low), .HIGH_EVENT_GROUP_LOCK(lk_high),
    .PORT_E_WAVEFORM_LOCK(lk_e), .PORT_C_WAVEFORM_LOCK(lk_c));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends with an idle cycle so a following call never re-drives psel in one step
  // Waits for ready however long it takes; only the bench timeout ends a hang
  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
    chk("slave error", {31'h0, e}, 32'h0);
  endtask

  task automatic locks_chk(input logic [3:0] exp);
    chk("lock outputs", {28'h0, lk_low, lk_high, lk_e, lk_c}, {28'h0, exp});
  endtask

  task automatic t_reset_values();
    rd_chk("delay reset", 12'h01c, 32'h0);
    rd_chk("event lock reset", 12'h020, 32'h0);
    rd_chk("wave lock reset", 12'h024, 32'h0);
    rd_chk("status reset", 12'h028, 32'h0);
    locks_chk(4'h0);
  endtask

  task automatic t_delay_reg();
    logic [31:0] r;
    logic        e;
    wr(12'h01c, 8'hf6);
    rd_chk("delay fields", 12'h01c, 32'h06);
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask

  // One ramp per call; every cycle of it is compared, so a step off by one shows
  task automatic ramp(input logic b, input logic [1:0] code, input int n);
    logic [2:0] exp;
    wr(12'h01c, b ? {4'h0, code, 2'h0} : {6'h0, code});
    if (b) en_b <= 1'b1;
    else en_a <= 1'b1;
    for (int k = 1; k <= 2 * n + 2; k++) begin
      @(posedge clk_i);
      #1;
      exp = (code == 2'h0 || k > 2 * n) ? 3'h7 : (k > n ? 3'h3 : 3'h1);
      chk("stage enables", {29'h0, b ? stage_b : stage_a}, {29'h0, exp});
      chk("idle port", {29'h0, b ? stage_a : stage_b}, 32'h0);
    end
    // Enable drops at an edge; stages stand that cycle and clear on the next
    @(posedge clk_i);
    if (b) en_b <= 1'b0;
    else en_a <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("stages off", {29'h0, stage_a | stage_b}, 32'h0);
    @(posedge clk_i);
  endtask

  task automatic t_ramps();
    ramp(1'b0, 2'h0, 0);
    ramp(1'b0, 2'h1, 2);
    ramp(1'b0, 2'h2, 8);
    // Longest step, the setting software picks to stay above a quarter of a microsecond
    ramp(1'b0, 2'h3, 32);
    ramp(1'b1, 2'h2, 8);
  endtask

  // Status shows port B ramping only while its sequence is still stepping
  task automatic t_status();
    wr(12'h01c, 8'h0c);
    en_b <= 1'b1;
    @(posedge clk_i);
    rd_chk("status ramping", 12'h028, 32'h2);
    en_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd_chk("status idle", 12'h028, 32'h0);
  endtask

  task automatic t_locks();
    wr(12'h020, 8'h11);
    wr(12'h024, 8'h05);
    rd_chk("event lock closed", 12'h020, 32'h0);
    locks_chk(4'h0);
    ccp_open <= 1'b1;
    wr(12'h020, 8'h01);
    locks_chk(4'h8);
    wr(12'h020, 8'hf0);
    locks_chk(4'hc);
    wr(12'h020, 8'h00);
    rd_chk("event lock sticky", 12'h020, 32'h11);
    wr(12'h024, 8'h04);
    locks_chk(4'he);
    wr(12'h024, 8'hfb);
    locks_chk(4'hf);
    wr(12'h024, 8'h00);
    rd_chk("wave lock sticky", 12'h024, 32'h05);
    ccp_open <= 1'b0;
  endtask

  // Mid-run reset must clear the sticky locks and the delay fields
  task automatic t_rereset();
    wr(12'h01c, 8'h0f);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values();
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ccp_open = 1'b0;
    en_a = 1'b0;
    en_b = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values();
    t_delay_reg();
    t_ramps();
    t_status();
    t_locks();
    t_rereset();
    wrap_up();
  end
endmodule
